// ===== bench/psr_core_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
// ***************************************************************
// Self-checking bench for the processor state register
// ***************************************************************
module psr_core_test;
  logic ref_clk_i, rst_n_i, ctl_wr_i, exc_i, brk_i, irq_req_i, irq_nmi_i, save_o, irq_ack_o;
  logic [31:0] ctl_wdata_i, state_o, saved_o, exp, d;
  logic [5:0] irq_level_i, irq_regset_i, g_lvl, g_rs;
  logic go, stop, g_nmi;
  int fails, checks_done, seed, i;
  logic [31:0] state_min, exp_min;
  logic ack_min;
  psr_core #(.NUM_REGSETS(2), .HAS_EIC(1'b1), .HAS_MMU(1'b1), .HAS_MPU(1'b0), .HAS_ECC(1'b0)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ctl_wr_i(ctl_wr_i), .ctl_wdata_i(ctl_wdata_i), .exc_i(exc_i),
    .brk_i(brk_i), .irq_req_i(irq_req_i), .irq_nmi_i(irq_nmi_i), .irq_level_i(irq_level_i),
    .irq_regset_i(irq_regset_i), .state_o(state_o), .saved_o(saved_o), .save_o(save_o), .irq_ack_o(irq_ack_o));
  psr_eic_model u_eic (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .go_i(go), .stop_i(stop), .nmi_i(g_nmi),
    .level_i(g_lvl), .regset_i(g_rs), .ack_i(irq_ack_o), .req_o(irq_req_i), .nmi_o(irq_nmi_i),
    .level_o(irq_level_i), .regset_o(irq_regset_i));
  // Smallest build shares every input; absent fields must hold their fixed read values
  psr_core #(.NUM_REGSETS(1), .HAS_EIC(1'b0), .HAS_MMU(1'b0), .HAS_MPU(1'b0), .HAS_ECC(1'b0)) u_min (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ctl_wr_i(ctl_wr_i), .ctl_wdata_i(ctl_wdata_i), .exc_i(exc_i),
    .brk_i(brk_i), .irq_req_i(irq_req_i), .irq_nmi_i(irq_nmi_i), .irq_level_i(irq_level_i),
    .irq_regset_i(irq_regset_i), .state_o(state_min), .saved_o(), .save_o(), .irq_ack_o(ack_min));
  // ***************************************************************
  // Expected-state functions
  // ***************************************************************
  function automatic logic [31:0] f_write(logic [31:0] s, logic [31:0] w);
    f_write = (w & 32'h0081_03FF) | (s & 32'h0040_FC00); // Nonmaskable bit and current set ignore writes
  endfunction : f_write
  function automatic logic [31:0] f_exc(logic [31:0] s, logic brk, logic intr, logic nmi, logic [5:0] rs);
    f_exc = s;
    if (brk || !s[2]) f_exc[16] = s[10];
    f_exc[15:10] = intr ? {5'h00, rs[0]} : 6'h00;
    f_exc[3] = s[3] | intr;
    f_exc[2] = 1'h1;
    f_exc[1:0] = 2'h0;
    f_exc[22] = s[22] | nmi;
  endfunction : f_exc
  function automatic logic f_acc(logic [31:0] s, logic nmi, logic [5:0] lvl, logic [5:0] rs);
    f_acc = nmi || (s[0] && lvl > s[9:4] && (s[23] || rs[0] != s[10]));
  endfunction : f_acc
  // ***************************************************************
  // Operations: each drives just after an edge and checks the answer
  // ***************************************************************
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic finish_op(logic [31:0] old, logic took);
    `CHK("save_o", took, save_o)
    if (took) `CHK("saved_o", old, saved_o)
    stop = !took;
    tick();
    stop = 1'h0;
    `CHK("state_o", exp, state_o)
    `CHK("min state_o", exp_min, state_min)
  endtask : finish_op
  task automatic do_write(logic [31:0] w);
    ctl_wr_i = 1'h1;
    ctl_wdata_i = w;
    tick();
    ctl_wr_i = 1'h0;
    exp = f_write(exp, w);
    exp_min = 32'h0080_0000 | {31'h0000_0000, w[0]}; // Only the processor enable is writable there
    finish_op(exp, 1'h0);
  endtask : do_write
  task automatic do_exc(logic brk);
    logic [31:0] old;
    old = exp;
    brk_i = brk;
    exc_i = !brk;
    tick();
    {brk_i, exc_i} = 2'h0;
    exp = f_exc(old, brk, 1'h0, 1'h0, 6'h00);
    exp_min = 32'h0080_0000;
    finish_op(old, 1'h1);
  endtask : do_exc
  task automatic do_irq(logic nmi, logic [5:0] lvl, logic [5:0] rs);
    logic [31:0] old;
    logic acc;
    old = exp;
    acc = f_acc(exp, nmi, lvl, rs);
    {go, g_nmi, g_lvl, g_rs} = {1'h1, nmi, lvl, rs};
    tick();
    go = 1'h0;
    tick();
    `CHK("irq_ack_o", acc, irq_ack_o)
    `CHK("min irq_ack_o", 1'h0, ack_min)
    if (acc) exp = f_exc(old, 1'h0, 1'h1, nmi, rs);
    finish_op(old, acc);
    if (acc && nmi) `CHK("nmi bit", 1'h1, state_o[22])
  endtask : do_irq
  task automatic tally_and_finish();
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // ***************************************************************
  // Clock, watchdog and main sequence
  // ***************************************************************
  initial begin
    ref_clk_i = 1'h0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // Run needs well under a thousand cycles; a hang stops here
  initial begin
    #16000;
    fails++;
    tally_and_finish();
  end
  initial begin
    {rst_n_i, ctl_wr_i, exc_i, brk_i, go, stop, g_nmi} = 7'h00;
    {ctl_wdata_i, g_lvl, g_rs} = 44'h0;
    seed = 85;
    tick();
    tick();
    rst_n_i = 1'h1;
    exp = 32'h0080_0000;
    exp_min = 32'h0080_0000;
    `CHK("reset state_o", exp, state_o)
    `CHK("reset min state_o", exp_min, state_min)
    `CHK("reset saved_o", 32'h0, saved_o)
    do_write(32'h0080_0011);
    do_irq(1'h0, 6'h01, 6'h01);
    do_irq(1'h0, 6'h02, 6'h01);
    do_irq(1'h0, 6'h3F, 6'h00);
    do_irq(1'h1, 6'h00, 6'h00);
    do_write(32'h0040_0401);
    do_irq(1'h0, 6'h05, 6'h00);
    do_irq(1'h0, 6'h05, 6'h01);
    do_exc(1'h1);
    do_exc(1'h0);
    // Random mix; software writes only implemented set numbers and never user mode with EH set
    for (i = 0; i < 60; i++) begin
      d = $random(seed);
      case (d[31:30])
        2'h0: begin
          if (d[2] && d[1]) d[1] = 1'h0;
          do_write(d & 32'h00C1_07FF);
        end
        2'h1: do_exc(d[29]);
        default: do_irq(d[28:26] == 3'h0, d[25:20], {5'h00, d[19]});
      endcase
    end
    tally_and_finish();
  end
endmodule : psr_core_test
`default_nettype wire

// ===== bench/psr_eic_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************************
// Behavioural external interrupt controller
// ***************************************************************
module psr_eic_model (
  input wire logic ref_clk_i,        // Processor clock
  input wire logic rst_n_i,          // Synchronous reset, active low
  input wire logic go_i,             // Raise a request with the fields below
  input wire logic stop_i,           // Withdraw a request that the core refuses
  input wire logic nmi_i,            // Nonmaskable flag to present
  input wire logic [5:0] level_i,    // Level to present
  input wire logic [5:0] regset_i,   // Register set to present
  input wire logic ack_i,            // Acknowledge from the core
  output logic req_o,                // Request to the core
  output logic nmi_o,                // Request is nonmaskable
  output logic [5:0] level_o,        // Requested level
  output logic [5:0] regset_o        // Requested register set
);
  logic pend;
  logic next_pend;
  logic [12:0] held;
  logic [12:0] next_held;
  // Request stands until the acknowledge or a stop is seen; idle lines show the inverse, never a stale value
  always_comb begin
    next_pend = pend;
    next_held = held;
    if (go_i) begin
      next_pend = 1'h1;
      next_held = {nmi_i, level_i, regset_i};
    end else if (pend && (ack_i || stop_i)) begin
      next_pend = 1'h0;
      next_held = ~held;
    end
  end
  // State registers
  always_ff @(posedge ref_clk_i) begin
    pend <= rst_n_i ? next_pend : 1'h0;
    held <= rst_n_i ? next_held : 13'h1FFF;
  end
  // Dropping on the acknowledge itself stops a held request from being taken twice
  assign req_o = pend & ~ack_i;
  assign {nmi_o, level_o, regset_o} = held;
endmodule : psr_eic_model
`default_nettype wire

// ===== logic/psr_core.sv
`timescale 1ns/100ps
`default_nettype none
module psr_core #(
  parameter int unsigned NUM_REGSETS = 2, // Implemented register sets
  parameter bit HAS_EIC = 1'b1,           // External controller interface present
  parameter bit HAS_MMU = 1'b1,           // MMU present
  parameter bit HAS_MPU = 1'b0,           // MPU present
  parameter bit HAS_ECC = 1'b0            // ECC present
) (
  input wire logic ref_clk_i,          // Processor clock
  input wire logic rst_n_i,            // Synchronous reset, active low
  input wire logic ctl_wr_i,           // Control write to the state register
  input wire logic [31:0] ctl_wdata_i, // Control write data
  input wire logic exc_i,              // Noninterrupt, nonbreak exception taken
  input wire logic brk_i,              // Break taken
  input wire logic irq_req_i,          // External controller request
  input wire logic irq_nmi_i,          // Request is nonmaskable
  input wire logic [5:0] irq_level_i,  // Requested level
  input wire logic [5:0] irq_regset_i, // Requested register set
  output logic [31:0] state_o,         // State register value, registered one cycle behind the fields
  output logic [31:0] saved_o,         // State captured at the last event
  output logic save_o,                 // Pulse: saved_o just captured
  output logic irq_ack_o               // Pulse: request taken
);
  localparam int unsigned SW = (NUM_REGSETS > 1) ? $clog2(NUM_REGSETS) : 1;
  localparam bit HAS_SRS = (NUM_REGSETS > 1);
  localparam bit HAS_REGSET_IRQ_ENABLE = HAS_EIC && HAS_SRS;
  localparam bit HAS_EH = HAS_MMU || HAS_ECC;
  localparam bit HAS_U = HAS_MMU || HAS_MPU;

  // Refuse configurations the set fields cannot hold
  if (NUM_REGSETS < 1 || NUM_REGSETS > psr_pkg::MAX_REGSETS) begin : g_chk
    $error("NUM_REGSETS out of range");
  end

  // ***************************************************************
  // State fields
  // ***************************************************************
  logic regset_irq_enable, nmi, ih, eh, umode, proc_irq_enable;
  logic [5:0] previous_regset, current_regset, il;
  logic next_regset_irq_enable, next_nmi, next_ih, next_eh, next_umode, next_pie;
  logic [5:0] next_prs, next_crs, next_il;
  logic [31:0] cur;
  logic [31:0] next_saved;
  logic next_save, next_ack;
  logic accept, take_irq, any_exc, copy_prs;
  logic [5:0] set_mask;

  // Only the implemented low bits of the set fields ever hold ones
  assign set_mask = HAS_SRS ? 6'((1 << SW) - 1) : 6'h00;

  // Live register image; absent fields are constants
  always_comb begin
    cur = 32'h0000_0000;
    cur[psr_pkg::BIT_REGSET_IRQ_ENABLE] = HAS_REGSET_IRQ_ENABLE ? regset_irq_enable : 1'h1;
    cur[psr_pkg::BIT_NMI] = nmi;
    cur[psr_pkg::PRS_LSB +: psr_pkg::FLD_W] = previous_regset;
    cur[psr_pkg::CRS_LSB +: psr_pkg::FLD_W] = current_regset;
    cur[psr_pkg::IL_LSB +: psr_pkg::FLD_W] = il;
    cur[psr_pkg::BIT_IH] = ih;
    cur[psr_pkg::BIT_EH] = eh;
    cur[psr_pkg::BIT_U] = umode;
    cur[psr_pkg::BIT_PIE] = proc_irq_enable;
  end

  psr_irq_gate u_gate (
    .req_i(irq_req_i && HAS_EIC),
    .nmi_i(irq_nmi_i),
    .level_i(irq_level_i),
    .regset_i(irq_regset_i & set_mask),
    .pie_i(proc_irq_enable),
    .regset_irq_enable_i(cur[psr_pkg::BIT_REGSET_IRQ_ENABLE]),
    .il_i(il),
    .crs_i(current_regset),
    .accept_o(accept)
  );

  // Next-state: software write first, hardware events override it,
  // so an event in the cycle of a clearing write is never lost.
  always_comb begin
    take_irq = accept && !brk_i && !exc_i;
    any_exc = brk_i || exc_i || take_irq;
    // Under an MMU, breaks always copy; interrupts and other exceptions copy only with EH still 0
    copy_prs = any_exc && (!HAS_MMU || brk_i || !eh);
    next_regset_irq_enable = regset_irq_enable;
    next_nmi = nmi;
    next_prs = previous_regset;
    next_crs = current_regset;
    next_il = il;
    next_ih = ih;
    next_eh = eh;
    next_umode = umode;
    next_pie = proc_irq_enable;
    if (ctl_wr_i) begin
      next_regset_irq_enable = ctl_wdata_i[psr_pkg::BIT_REGSET_IRQ_ENABLE] && HAS_REGSET_IRQ_ENABLE;
      next_prs = ctl_wdata_i[psr_pkg::PRS_LSB +: psr_pkg::FLD_W] & set_mask;
      next_il = HAS_EIC ? ctl_wdata_i[psr_pkg::IL_LSB +: psr_pkg::FLD_W] : 6'h00;
      next_ih = ctl_wdata_i[psr_pkg::BIT_IH] && HAS_EIC;
      next_eh = ctl_wdata_i[psr_pkg::BIT_EH] && HAS_EH;
      next_umode = ctl_wdata_i[psr_pkg::BIT_U] && HAS_U;
      next_pie = ctl_wdata_i[psr_pkg::BIT_PIE];
    end
    if (any_exc) begin
      next_pie = 1'h0;
      next_umode = 1'h0;
      next_eh = HAS_EH;
    end
    if (copy_prs) begin
      next_prs = current_regset;
    end
    if (brk_i || exc_i) begin
      next_crs = 6'h00;
    end else if (take_irq) begin
      next_crs = irq_regset_i & set_mask;
      next_ih = 1'h1;
      if (irq_nmi_i) begin
        next_nmi = 1'h1;
      end
    end
    // Saved copy is the image before this cycle's update
    next_save = any_exc;
    next_saved = any_exc ? cur : saved_o;
    next_ack = take_irq;
  end

  // Registers; reset values per field
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      regset_irq_enable <= psr_pkg::RST_REGSET_IRQ_ENABLE;
      nmi <= psr_pkg::RST_BIT;
      previous_regset <= psr_pkg::RST_FLD;
      current_regset <= psr_pkg::RST_FLD;
      il <= psr_pkg::RST_FLD;
      ih <= psr_pkg::RST_BIT;
      eh <= psr_pkg::RST_BIT;
      umode <= psr_pkg::RST_BIT;
      proc_irq_enable <= psr_pkg::RST_BIT;
      saved_o <= 32'h0000_0000;
      save_o <= 1'h0;
      irq_ack_o <= 1'h0;
      state_o <= 32'h0080_0000;
    end else begin
      regset_irq_enable <= next_regset_irq_enable;
      nmi <= next_nmi;
      previous_regset <= next_prs;
      current_regset <= next_crs;
      il <= next_il;
      ih <= next_ih;
      eh <= next_eh;
      umode <= next_umode;
      proc_irq_enable <= next_pie;
      saved_o <= next_saved;
      save_o <= next_save;
      irq_ack_o <= next_ack;
      state_o <= cur;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence s_nmi_taken;
    irq_req_i && irq_nmi_i && !brk_i && !exc_i && HAS_EIC;
  endsequence
  sequence s_exc_taken;
    exc_i || brk_i;
  endsequence

  a_reset_values: assert property (@(posedge ref_clk_i) !rst_n_i |=>
    (state_o == 32'h0080_0000) && regset_irq_enable && !nmi && current_regset == 6'h00 && !proc_irq_enable)
    else $error("state not at reset value");
  a_nmi_sets: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) s_nmi_taken |=> nmi ##1
    state_o[psr_pkg::BIT_NMI])
    else $error("nmi bit not set");
  a_nmi_readonly: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ctl_wr_i && !take_irq |=> nmi == $past(nmi))
    else $error("nmi bit written by software");
  a_crs_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) s_exc_taken |=> current_regset == 6'h00)
    else $error("current set not cleared");
  a_prs_copy: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    any_exc && (!HAS_MMU || brk_i || !eh) |=> previous_regset == $past(current_regset) && save_o)
    else $error("previous set not copied");
  a_saved_pre: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    any_exc |=> saved_o == $past(cur))
    else $error("saved copy not pre-event state");
  a_level_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    irq_req_i && !irq_nmi_i && irq_level_i <= il |=> !irq_ack_o)
    else $error("low level interrupt taken");
  a_pie_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    irq_req_i && !irq_nmi_i && !proc_irq_enable |=> !irq_ack_o)
    else $error("maskable taken with enable off");
  a_regset_irq_enable_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    irq_req_i && !irq_nmi_i && !cur[psr_pkg::BIT_REGSET_IRQ_ENABLE] && (irq_regset_i & set_mask) == current_regset |=> !irq_ack_o)
    else $error("set in use interrupted with enable off");
  a_ih_sets: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    take_irq |=> ih && irq_ack_o ##1 state_o[psr_pkg::BIT_IH])
    else $error("handler bit not set");
  a_eh_sets: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    any_exc && HAS_EH |=> eh)
    else $error("exception handler bit not set");
  a_set_bits: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ((previous_regset | current_regset) & ~set_mask) == 6'h00)
    else $error("unused set bits nonzero");
endmodule : psr_core
`default_nettype wire

// ===== logic/psr_irq_gate.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************************
// Decides whether an external request may be serviced now
// ***************************************************************
module psr_irq_gate (
  input wire logic req_i,          // Request valid
  input wire logic nmi_i,          // Request is nonmaskable
  input wire logic [5:0] level_i,  // Requested level
  input wire logic [5:0] regset_i, // Requested register set
  input wire logic pie_i,          // Processor interrupt enable
  input wire logic regset_irq_enable_i,         // Register-set interrupt enable
  input wire logic [5:0] il_i,     // Level threshold
  input wire logic [5:0] crs_i,    // Set in use
  output logic accept_o            // Request may be taken
);
  logic maskable_ok;
  logic set_ok;

  // Nonmaskable requests bypass enable and level checks
  always_comb begin
    set_ok = regset_irq_enable_i || (regset_i != crs_i);
    maskable_ok = pie_i && (level_i > il_i) && set_ok;
    accept_o = req_i && (nmi_i || maskable_ok);
  end
endmodule : psr_irq_gate
`default_nettype wire

// ===== logic/psr_pkg.sv
`default_nettype none
package psr_pkg;
  // ***************************************************************
  // Field layout of the processor state register
  // ***************************************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FLD_W = 6;
  localparam int unsigned BIT_REGSET_IRQ_ENABLE = 23;
  localparam int unsigned BIT_NMI = 22;
  localparam int unsigned PRS_LSB = 16;
  localparam int unsigned CRS_LSB = 10;
  localparam int unsigned IL_LSB = 4;
  localparam int unsigned BIT_IH = 3;
  localparam int unsigned BIT_EH = 2;
  localparam int unsigned BIT_U = 1;
  localparam int unsigned BIT_PIE = 0;
  // ***************************************************************
  // Reset values and limits
  // ***************************************************************
  localparam logic RST_REGSET_IRQ_ENABLE = 1'h1;
  localparam logic RST_BIT = 1'h0;
  localparam logic [5:0] RST_FLD = 6'h00;
  localparam int unsigned MAX_REGSETS = 64;
endpackage : psr_pkg
`default_nettype wire
